// >>> sbp_pkg.sv
package sbp_pkg;
    // widths
    localparam int MEM_AW = 11;
    localparam int DW     = 8;
    localparam int MOT_W  = 56;

    // register addresses
    localparam logic [6:0] A_MOTION    = 7'h02;
    localparam logic [6:0] A_DX        = 7'h03;
    localparam logic [6:0] A_DY        = 7'h04;
    localparam logic [6:0] A_SURFACE_QUALITY     = 7'h05;
    localparam logic [6:0] A_PEAK      = 7'h07;
    localparam logic [6:0] A_CFG       = 7'h0A;
    localparam logic [6:0] A_DOUT_LO   = 7'h0C;
    localparam logic [6:0] A_DOUT_HI   = 7'h0D;
    localparam logic [6:0] A_SHUT_LO   = 7'h0E;
    localparam logic [6:0] A_SHUT_HI   = 7'h0F;
    localparam logic [6:0] A_FRAME_CAP = 7'h13;
    localparam logic [6:0] A_DL_EN     = 7'h14;
    localparam logic [6:0] A_FW_VER    = 7'h1F;
    localparam logic [6:0] A_PREP_A    = 7'h20;
    localparam logic [6:0] A_PREP_B    = 7'h23;
    localparam logic [6:0] A_PREP_C    = 7'h24;
    localparam logic [6:0] A_PIX_BURST = 7'h40;
    localparam logic [6:0] A_MOT_BURST = 7'h50;
    localparam logic [6:0] A_FW_LOAD   = 7'h60;

    // written key values
    localparam logic [7:0] PREP_A_VAL   = 8'h44;
    localparam logic [7:0] PREP_B_VAL   = 8'h07;
    localparam logic [7:0] PREP_C_VAL   = 8'h88;
    localparam logic [7:0] DL_GO_VAL    = 8'h18;
    localparam logic [7:0] SELFTEST_VAL = 8'h15;

    // configuration
    localparam logic [7:0] CFG_RESET    = 8'h09;
    localparam int         CFG_LAMP_BIT = 6;

    // lengths and indices
    localparam logic [10:0] FW_LEN     = 11'h7C2;
    localparam logic [10:0] PIX_TOTAL  = 11'h600;
    localparam logic [10:0] PIX_SECOND = 11'h384;
    localparam logic [10:0] MOT_LAST   = 11'h006;
    localparam logic [10:0] IDX_MAX    = 11'h7FF;
    localparam logic [2:0]  BIT_LAST   = 3'h7;

    // pixel byte marks
    localparam int PIX_MSB  = 7;
    localparam int PIX_MARK = 6;

    // self-test checksum
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    typedef enum {CAP_IDLE, CAP_WAIT, CAP_FILL, CAP_DONE} sbp_cap_t;
endpackage

// >>> sbp_mem.sv
`timescale 1ns/1ps
module sbp_mem #(
    parameter int AW = 11,
    parameter int DW = 8
) (
    // clock
    input  wire logic          clk,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // read port
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    // one write, registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// >>> sbp_port.sv
`timescale 1ns/1ps
module sbp_port (
    // system clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // serial link
    input  wire logic        sclk,
    input  wire logic        ncs,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe_n,
    // sensor core values
    input  wire logic [7:0]  motion_status,
    input  wire logic [7:0]  delta_x,
    input  wire logic [7:0]  delta_y,
    input  wire logic [7:0]  surface_quality,
    input  wire logic [15:0] shutter,
    input  wire logic [7:0]  peak_pixel,
    // pixel stream
    input  wire logic        pix_valid,
    input  wire logic        pix_sof,
    input  wire logic [5:0]  pix_value,
    // lamp and power
    input  wire logic        light_phase,
    input  wire logic        power_down_n,
    output logic             lamp_drive_out,
    output logic             tracking_enable
);
    import sbp_pkg::*;

    // serial side state
    logic        port_rst;
    logic [2:0]  bit_cnt_q;
    logic [6:0]  shin_q;
    logic        in_data_q;
    logic [6:0]  addr_q;
    logic        wr_q;
    logic [10:0] idx_q;
    logic        done_q;
    logic [7:0]  out_q;
    logic [7:0]  byte_in;
    logic        byte_end;
    logic        burst_more;
    logic [7:0]  tx_byte;
    logic [55:0] mot_shift;
    // crossing words
    logic        rq_tgl_q;
    logic [6:0]  rq_addr_q;
    logic [10:0] rq_idx_q;
    logic        wr_tgl_q;
    logic [6:0]  wr_addr_q;
    logic [7:0]  wr_data_q;
    // system side state
    logic [2:0]  rq_s_q;
    logic [2:0]  wr_s_q;
    logic [1:0]  pd_s_q;
    logic        pd;
    logic        rq_evt;
    logic        wr_evt;
    logic        rd_pend_q;
    logic [7:0]  rd_word_q;
    logic [7:0]  rd_mux;
    logic [55:0] mot_snap_q;
    logic [55:0] mot_live;
    logic [7:0]  cfg_q;
    logic [2:0]  prep_q;
    logic        dl_armed_q;
    logic [10:0] fw_ptr_q;
    logic        fw_loaded_q;
    logic [7:0]  fw_ver_q;
    sbp_cap_t    cap_q;
    logic [10:0] cap_idx_q;
    logic        grab_rdy_q;
    logic        cap_we;
    logic        ld_we;
    logic        cap_start;
    logic        crc_start;
    logic        crc_busy_q;
    logic [10:0] crc_addr_q;
    logic        crc_iss_q;
    logic        crc_iss_last_q;
    logic [15:0] crc_q;
    logic [15:0] crc_out_q;
    logic [10:0] crc_run_q;
    logic        mem_we;
    logic [10:0] mem_waddr;
    logic [7:0]  mem_wdata;
    logic [10:0] mem_raddr;
    logic [7:0]  mem_rdata;
    logic [7:0]  pix_byte;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // serial port held in reset while deselected
    assign port_rst   = ncs | ~rstn;
    assign byte_in    = {shin_q, mosi};
    assign byte_end   = (bit_cnt_q == BIT_LAST) && !done_q;
    assign burst_more = (wr_q && addr_q == A_FW_LOAD) || (!wr_q && addr_q == A_PIX_BURST)
                      || (!wr_q && addr_q == A_MOT_BURST && idx_q < MOT_LAST);

    // receive shifter and byte pointer on rising edges
    always_ff @(posedge sclk or posedge port_rst) begin
        if (port_rst) begin
            bit_cnt_q <= 3'h0;
            shin_q    <= 7'h00;
            in_data_q <= 1'b0;
            addr_q    <= 7'h00;
            wr_q      <= 1'b0;
            idx_q     <= 11'h000;
            done_q    <= 1'b0;
        end else if (!done_q) begin
            shin_q    <= byte_in[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == BIT_LAST) begin
                if (!in_data_q) begin
                    addr_q    <= byte_in[6:0];
                    wr_q      <= byte_in[7];
                    in_data_q <= 1'b1;
                end else begin
                    if (idx_q != IDX_MAX) begin
                        idx_q <= idx_q + 11'h001;
                    end
                    done_q <= !burst_more;
                end
            end
        end
    end

    // events toward the system side, kept across deselect
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            rq_tgl_q  <= 1'b0;
            rq_addr_q <= 7'h00;
            rq_idx_q  <= 11'h000;
            wr_tgl_q  <= 1'b0;
            wr_addr_q <= 7'h00;
            wr_data_q <= 8'h00;
        end else if (byte_end) begin
            if (!in_data_q && !byte_in[7]) begin
                rq_tgl_q  <= ~rq_tgl_q;
                rq_addr_q <= byte_in[6:0];
                rq_idx_q  <= 11'h000;
            end else if (in_data_q && !wr_q && addr_q == A_PIX_BURST) begin
                rq_tgl_q  <= ~rq_tgl_q;
                rq_idx_q  <= (idx_q == IDX_MAX) ? IDX_MAX : idx_q + 11'h001;
            end else if (in_data_q && wr_q) begin
                wr_tgl_q  <= ~wr_tgl_q;
                wr_addr_q <= addr_q;
                wr_data_q <= byte_in;
            end
        end
    end

    // motion bytes picked from the snapshot by pointer
    assign mot_shift = mot_snap_q << {idx_q[2:0], 3'h0};
    assign tx_byte   = (addr_q == A_MOT_BURST) ? mot_shift[55:48] : rd_word_q;

    // transmit shifter on falling edges
    always_ff @(negedge sclk or posedge port_rst) begin
        if (port_rst) begin
            out_q     <= 8'h00;
            miso      <= 1'b0;
            miso_oe_n <= 1'b1;
        end else if (in_data_q && !wr_q && !done_q) begin
            if (bit_cnt_q == 3'h0) begin
                miso  <= tx_byte[7];
                out_q <= {tx_byte[6:0], 1'b0};
            end else begin
                miso  <= out_q[7];
                out_q <= {out_q[6:0], 1'b0};
            end
            miso_oe_n <= 1'b0;
        end else begin
            miso_oe_n <= 1'b1;
        end
    end

    // toggle and pin synchronisers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rq_s_q <= 3'h0;
            wr_s_q <= 3'h0;
            pd_s_q <= 2'h0;
        end else begin
            rq_s_q <= {rq_s_q[1:0], rq_tgl_q};
            wr_s_q <= {wr_s_q[1:0], wr_tgl_q};
            pd_s_q <= {pd_s_q[0], power_down_n};
        end
    end

    assign pd     = !pd_s_q[1];
    assign rq_evt = (rq_s_q[2] ^ rq_s_q[1]) && !pd;
    assign wr_evt = (wr_s_q[2] ^ wr_s_q[1]) && !pd;
    assign mot_live = {motion_status, delta_x, delta_y, surface_quality, shutter, peak_pixel};

    // read data selection, unmapped reads give zero
    always_comb begin
        rd_mux = 8'h00;
        if (rq_addr_q == A_PIX_BURST) begin
            if (grab_rdy_q && rq_idx_q < PIX_TOTAL) begin
                rd_mux = mem_rdata;
            end
        end else if (rq_addr_q == A_MOTION) begin
            rd_mux = motion_status;
        end else if (rq_addr_q == A_DX) begin
            rd_mux = delta_x;
        end else if (rq_addr_q == A_DY) begin
            rd_mux = delta_y;
        end else if (rq_addr_q == A_SURFACE_QUALITY) begin
            rd_mux = surface_quality;
        end else if (rq_addr_q == A_PEAK) begin
            rd_mux = peak_pixel;
        end else if (rq_addr_q == A_SHUT_LO) begin
            rd_mux = shutter[7:0];
        end else if (rq_addr_q == A_SHUT_HI) begin
            rd_mux = shutter[15:8];
        end else if (rq_addr_q == A_CFG) begin
            rd_mux = cfg_q;
        end else if (rq_addr_q == A_DOUT_LO) begin
            rd_mux = crc_out_q[7:0];
        end else if (rq_addr_q == A_DOUT_HI) begin
            rd_mux = crc_out_q[15:8];
        end else if (rq_addr_q == A_FW_VER) begin
            rd_mux = fw_loaded_q ? fw_ver_q : 8'h00;
        end
    end

    // read pipeline and motion snapshot
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_pend_q  <= 1'b0;
            rd_word_q  <= 8'h00;
            mot_snap_q <= '0;
        end else begin
            rd_pend_q <= rq_evt;
            if (rd_pend_q) begin
                rd_word_q <= rd_mux;
            end
            if (rq_evt && rq_addr_q == A_MOT_BURST) begin
                mot_snap_q <= mot_live;
            end
        end
    end

    assign cap_start = wr_evt && wr_addr_q == A_FRAME_CAP;
    assign crc_start = wr_evt && wr_addr_q == A_DL_EN && wr_data_q == SELFTEST_VAL;

    // configuration and download control
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q       <= CFG_RESET;
            prep_q      <= 3'h0;
            dl_armed_q  <= 1'b0;
            fw_ptr_q    <= 11'h000;
            fw_loaded_q <= 1'b0;
            fw_ver_q    <= 8'h00;
        end else if (cap_start) begin
            dl_armed_q  <= 1'b0;
            fw_loaded_q <= 1'b0;
        end else if (wr_evt) begin
            if (wr_addr_q == A_CFG) begin
                cfg_q <= wr_data_q;
            end else if (wr_addr_q == A_PREP_A) begin
                prep_q[0] <= (wr_data_q == PREP_A_VAL);
            end else if (wr_addr_q == A_PREP_B) begin
                prep_q[1] <= (wr_data_q == PREP_B_VAL);
            end else if (wr_addr_q == A_PREP_C) begin
                prep_q[2] <= (wr_data_q == PREP_C_VAL);
            end else if (wr_addr_q == A_DL_EN && wr_data_q == DL_GO_VAL && &prep_q) begin
                dl_armed_q  <= 1'b1;
                fw_ptr_q    <= 11'h000;
                fw_loaded_q <= 1'b0;
            end else if (ld_we) begin
                fw_ptr_q <= fw_ptr_q + 11'h001;
                if (fw_ptr_q == 11'h000) begin
                    fw_ver_q <= wr_data_q;
                end
                if (fw_ptr_q == FW_LEN - 11'h001) begin
                    fw_loaded_q <= 1'b1;
                end
            end
        end
    end

    // frame capture sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_q      <= CAP_IDLE;
            cap_idx_q  <= 11'h000;
            grab_rdy_q <= 1'b0;
        end else if (cap_start) begin
            cap_q      <= CAP_WAIT;
            cap_idx_q  <= 11'h000;
            grab_rdy_q <= 1'b0;
        end else if (cap_we) begin
            case (cap_q)
                CAP_WAIT: begin
                    cap_q     <= CAP_FILL;
                    cap_idx_q <= 11'h001;
                end
                CAP_FILL: begin
                    cap_idx_q <= cap_idx_q + 11'h001;
                    if (cap_idx_q == PIX_TOTAL - 11'h001) begin
                        cap_q      <= CAP_DONE;
                        grab_rdy_q <= 1'b1;
                    end
                end
                default: begin
                    cap_q <= cap_q;
                end
            endcase
        end
    end

    // self-test checksum over the firmware image
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crc_busy_q     <= 1'b0;
            crc_addr_q     <= 11'h000;
            crc_iss_q      <= 1'b0;
            crc_iss_last_q <= 1'b0;
            crc_q          <= CRC_INIT;
            crc_out_q      <= 16'h0000;
        end else begin
            crc_iss_q      <= crc_busy_q;
            crc_iss_last_q <= crc_busy_q && crc_addr_q == FW_LEN - 11'h001;
            if (crc_start) begin
                crc_busy_q <= 1'b1;
                crc_addr_q <= 11'h000;
                crc_q      <= CRC_INIT;
            end else if (crc_busy_q) begin
                crc_addr_q <= crc_addr_q + 11'h001;
                if (crc_addr_q == FW_LEN - 11'h001) begin
                    crc_busy_q <= 1'b0;
                end
            end
            if (crc_iss_q) begin
                crc_q <= crc_step(crc_q, mem_rdata);
            end
            if (crc_iss_last_q) begin
                crc_out_q <= crc_step(crc_q, mem_rdata);
            end
        end
    end

    // cycles the checksum walk has run, for its length check
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crc_run_q <= 11'h000;
        end else if (crc_start) begin
            crc_run_q <= 11'h000;
        end else if (crc_busy_q) begin
            crc_run_q <= crc_run_q + 11'h001;
        end
    end

    // memory write and read steering
    assign pix_byte  = {1'b1, (cap_idx_q == 11'h000 || cap_idx_q == PIX_SECOND), pix_value};
    assign cap_we    = !pd && pix_valid && ((cap_q == CAP_WAIT && pix_sof) || cap_q == CAP_FILL);
    assign ld_we     = wr_evt && wr_addr_q == A_FW_LOAD && dl_armed_q && fw_ptr_q < FW_LEN;
    assign mem_we    = cap_we || ld_we;
    assign mem_waddr = cap_we ? cap_idx_q : fw_ptr_q;
    assign mem_wdata = cap_we ? pix_byte : wr_data_q;
    assign mem_raddr = crc_busy_q ? crc_addr_q : rq_idx_q;

    sbp_mem #(
        .AW (MEM_AW),
        .DW (DW)
    ) u_mem (
        .clk   (clk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // lamp drive and tracking state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lamp_drive_out  <= 1'b0;
            tracking_enable <= 1'b1;
        end else begin
            lamp_drive_out <= pd ? 1'b0 : (cfg_q[CFG_LAMP_BIT] ? light_phase : 1'b1);
            if (cap_start) begin
                tracking_enable <= 1'b0;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_fw_bound;
        fw_ptr_q <= FW_LEN;
    endproperty
    a_fw_bound: assert property (p_fw_bound) else $error("firmware write past image end");

    property p_pix_mark;
        cap_we |-> mem_wdata[PIX_MSB] && (mem_wdata[PIX_MARK] == (mem_waddr == 11'h000 || mem_waddr == PIX_SECOND));
    endproperty
    a_pix_mark: assert property (p_pix_mark) else $error("pixel byte marks wrong");

    property p_pix_zero;
        rd_pend_q && rq_addr_q == A_PIX_BURST && (!grab_rdy_q || rq_idx_q >= PIX_TOTAL) |=> rd_word_q == 8'h00;
    endproperty
    a_pix_zero: assert property (p_pix_zero) else $error("pixel read not zero");

    property p_cap_stop;
        cap_start |=> !tracking_enable && !fw_loaded_q && !dl_armed_q;
    endproperty
    a_cap_stop: assert property (p_cap_stop) else $error("capture left tracking or firmware");

    property p_lamp;
        pd |=> !lamp_drive_out ##0 (!pd && !cfg_q[CFG_LAMP_BIT])[*2] |=> lamp_drive_out;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp drive wrong");

    property p_snap;
        rq_evt && rq_addr_q == A_MOT_BURST |=> mot_snap_q == $past(mot_live);
    endproperty
    a_snap: assert property (p_snap) else $error("motion snapshot not taken");

    property p_crc_len;
        $fell(crc_busy_q) |-> crc_run_q == FW_LEN ##2 crc_out_q == crc_q;
    endproperty
    a_crc_len: assert property (p_crc_len) else $error("self-test checksum not produced");

    property p_cap_done;
        cap_we && cap_q == CAP_FILL && cap_idx_q == PIX_TOTAL - 11'h001 && !cap_start |=> grab_rdy_q;
    endproperty
    a_cap_done: assert property (p_cap_done) else $error("capture not finished at 1536");

    property p_unmapped;
        rd_pend_q && rq_addr_q == A_FRAME_CAP |=> rd_word_q == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// >>> sbp_host.sv
`timescale 1ns/1ps
module sbp_host (
    // serial link
    output logic      sclk,
    output logic      ncs,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe_n
);
    // idle: select high, clock parked high, data pulled up
    initial begin
        sclk = 1'b1;
        ncs  = 1'b1;
        mosi = 1'b1;
    end
    // open a frame
    task automatic open_f();
        ncs = 1'b0;
        #100;
    endtask
    // n bits msb first, out on fall, sample on rise
    task automatic xb(input logic [7:0] tx, input int n, output logic [7:0] rx, output logic oe);
        rx = 8'h00;
        oe = 1'b1;
        for (int i = 7; i > 7 - n; i--) begin
            sclk = 1'b0;
            mosi = tx[i];
            #7.5;
            sclk = 1'b1;
            rx[i] = miso_oe_n ? ~miso : miso; // released line gives no valid level
            oe = miso_oe_n;
            #7.5;
        end
    endtask
    // close frame, release data, exit gap
    task automatic close_f();
        #20;
        ncs  = 1'b1;
        mosi = 1'b1;
        #400;
    endtask
    // two-byte write
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       o;
        open_f();
        xb({1'b1, a}, 8, r, o);
        xb(d, 8, r, o);
        close_f();
    endtask
    // two-byte read, gap before data
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        logic o;
        open_f();
        xb({1'b0, a}, 8, d, o);
        #400;
        xb(8'hFF, 8, d, o);
        close_f();
    endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
    import sbp_pkg::*;
    typedef struct packed {logic [6:0] a; logic [7:0] e;} sbp_row_t;
    // design signals
    logic        clk, rstn, sclk, ncs, mosi, miso, miso_oe_n;
    logic [7:0]  motion_status, delta_x, delta_y, surface_quality, peak_pixel, d, b;
    logic [15:0] shutter, crc;
    logic        pix_valid, pix_sof, light_phase, power_down_n, lamp_drive_out, tracking_enable, o;
    logic [5:0]  pix_value;
    int          err_count, checks_done, cyc;
    sbp_row_t    rows [11] = '{'{A_MOTION, 8'hA1}, '{A_DX, 8'h12}, '{A_DY, 8'h34}, '{A_SURFACE_QUALITY, 8'h56},
        '{A_PEAK, 8'hBC}, '{A_SHUT_LO, 8'h9A}, '{A_SHUT_HI, 8'h78}, '{A_CFG, CFG_RESET},
        '{A_FRAME_CAP, 8'h00}, '{A_FW_VER, 8'h00}, '{7'h30, 8'h00}};
    logic [7:0]  mot [7] = '{8'hA1, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC};

    sbp_port sbp_port_inst (.clk(clk), .rstn(rstn), .sclk(sclk), .ncs(ncs), .mosi(mosi), .miso(miso),
        .miso_oe_n(miso_oe_n), .motion_status(motion_status), .delta_x(delta_x), .delta_y(delta_y),
        .surface_quality(surface_quality), .shutter(shutter), .peak_pixel(peak_pixel),
        .pix_valid(pix_valid), .pix_sof(pix_sof), .pix_value(pix_value), .light_phase(light_phase),
        .power_down_n(power_down_n), .lamp_drive_out(lamp_drive_out), .tracking_enable(tracking_enable));
    sbp_host sbp_host_inst (.sclk(sclk), .ncs(ncs), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n));

    // system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic do_reset();
        if ($time > 0) tick(1);
        rstn <= 1'b0;
        tick(16);
        rstn <= 1'b1;
        tick(4);
    endtask
    // bitwise checksum step, msb first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] v);
        for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ v[k]) ? CRC_POLY : 16'h0000);
        return c;
    endfunction
    function automatic logic [7:0] pexp(input int k);
        return (k < 1536) ? {1'b1, (k == 0 || k == 900), 6'(k)} : 8'h00;
    endfunction
    task automatic pix_read(input int n);
        sbp_host_inst.open_f();
        sbp_host_inst.xb({1'b0, A_PIX_BURST}, 8, d, o);
        #400;
        for (int k = 0; k < n; k++) begin
            sbp_host_inst.xb(8'hFF, 8, d, o);
            #200;
            chk(d, pexp(k));
        end
        sbp_host_inst.close_f();
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        {err_count, checks_done, cyc} = '0;
        {pix_valid, pix_sof, pix_value, light_phase} <= '0;
        {motion_status, delta_x, delta_y, surface_quality} <= {8'hA1, 8'h12, 8'h34, 8'h56};
        {shutter, peak_pixel, power_down_n} <= {16'h789A, 8'hBC, 1'b1};
        do_reset();
        chk(8'(miso_oe_n), 8'h01);
        chk(8'(lamp_drive_out), 8'h01);
        foreach (rows[i]) begin
            sbp_host_inst.rd(rows[i].a, d);
            chk(d, rows[i].e);
        end
        $display("done: table");
        sbp_host_inst.open_f();
        sbp_host_inst.xb({1'b0, A_MOT_BURST}, 8, d, o);
        #400;
        @(posedge clk) motion_status <= 8'h5A; // live value moves after the snapshot
        foreach (mot[i]) begin
            sbp_host_inst.xb(8'hFF, 8, d, o);
            chk(d, mot[i]);
        end
        sbp_host_inst.xb(8'hFF, 8, d, o);
        chk(8'(o), 8'h01);
        sbp_host_inst.close_f();
        $display("done: motion burst");
        sbp_host_inst.wr(A_CFG, 8'h49);
        tick(4);
        chk(8'(lamp_drive_out), 8'h00);
        light_phase <= 1'b1;
        tick(4);
        chk(8'(lamp_drive_out), 8'h01);
        sbp_host_inst.open_f();
        sbp_host_inst.xb({1'b1, A_CFG}, 8, d, o);
        sbp_host_inst.xb(8'h00, 4, d, o);
        sbp_host_inst.close_f();
        sbp_host_inst.rd(A_CFG, d);
        chk(d, 8'h49);
        sbp_host_inst.wr(7'h30, 8'hFF);
        sbp_host_inst.rd(7'h30, d);
        chk(d, 8'h00);
        @(posedge clk) power_down_n <= 1'b0;
        tick(4);
        chk(8'(lamp_drive_out), 8'h00);
        power_down_n <= 1'b1;
        tick(4);
        sbp_host_inst.rd(A_CFG, d);
        chk(d, 8'h49);
        $display("done: write, abort, lamp, power");
        do_reset();
        sbp_host_inst.wr(A_PREP_A, PREP_A_VAL);
        sbp_host_inst.wr(A_PREP_B, PREP_B_VAL);
        sbp_host_inst.wr(A_PREP_C, PREP_C_VAL);
        #2000;
        sbp_host_inst.wr(A_DL_EN, DL_GO_VAL);
        sbp_host_inst.open_f();
        sbp_host_inst.xb({1'b1, A_FW_LOAD}, 8, d, o);
        crc = CRC_INIT;
        for (int i = 0; i < 1990; i++) begin
            b = 8'(i * 7 + 3);
            sbp_host_inst.xb(b, 8, d, o);
            #200;
            if (i < 1986) crc = crc_step(crc, b);
        end
        sbp_host_inst.close_f();
        sbp_host_inst.rd(A_FW_VER, d);
        chk(d, 8'h03);
        sbp_host_inst.wr(A_DL_EN, SELFTEST_VAL);
        tick(2100);
        sbp_host_inst.rd(A_DOUT_LO, d);
        chk(d, crc[7:0]);
        sbp_host_inst.rd(A_DOUT_HI, d);
        chk(d, crc[15:8]);
        $display("done: download");
        sbp_host_inst.rd(A_PIX_BURST, d);
        chk(d, 8'h00);
        sbp_host_inst.wr(A_FRAME_CAP, 8'h00);
        chk(8'(tracking_enable), 8'h00);
        for (int j = 0; j < 1803; j++) begin
            @(posedge clk);
            pix_valid <= 1'b1;
            pix_sof <= (j == 3 || j == 903);
            pix_value <= 6'(j - 3);
        end
        @(posedge clk) pix_valid <= 1'b0;
        tick(10);
        pix_read(3);
        pix_read(1540);
        do_reset();
        chk(8'(tracking_enable), 8'h01);
        $display("done: capture");
        finish_test();
    end
endmodule
